//--- design/bus_matrix_pkg.sv
// Constants, register map and state types of the bus matrix access control
package bus_matrix_pkg;
  localparam logic [7:0]  OFS_PROT_BASE  = 8'h00;
  localparam logic [7:0]  OFS_PROT_SIZE  = 8'h04;
  localparam logic [7:0]  OFS_MATRIX_CFG = 8'h08;
  localparam logic [7:0]  OFS_STATUS     = 8'h0C;
  localparam logic [7:0]  OFS_STATUS_CLR = 8'h10;
  localparam logic [7:0]  OFS_IRQ_MASK   = 8'h14;
  localparam int          ADR_W          = 8;
  localparam int          REGION_ON_BIT  = 0;
  localparam int          WEIGHTED_BIT   = 3;
  localparam int          GATE_FAB       = 0;
  localparam int          GATE_MAC       = 1;
  localparam int          GATE_DMA       = 2;
  localparam int          GATE_W         = 3;
  localparam int          CFG_W          = 4;
  localparam int          SIZE_W         = 5;
  localparam int          FLAG_W         = 5;
  localparam int          FLAG_LSB       = 4;
  localparam int          FLAG_CORE_ID   = 0;
  localparam int          FLAG_CORE_SYS  = 1;
  localparam int          FLAG_FAB       = 2;
  localparam logic [31:0] BASE_RST       = 32'h0000_0000;
  localparam logic [4:0]  SIZE_RST       = 5'h1E;
  localparam logic [3:0]  CFG_RST        = 4'h0;
  localparam logic [4:0]  MASK_RST       = 5'h1F;
  localparam logic [4:0]  FLAG_RST       = 5'h00;
  // Region is 2^(code+1) bytes
  localparam logic [5:0]  SIZE_TO_N      = 6'h01;
  // One bit per size code, set where the code is a defined size
  localparam logic [31:0] SIZE_VALID     = 32'h4447_E440;
  typedef enum logic [1:0] {
    RESP_IDLE = 2'b00,
    RESP_WAIT = 2'b01,
    RESP_DONE = 2'b10
  } err_state_t;
endpackage : bus_matrix_pkg

//--- design/fab_check_if.sv
// Interface between the control top, the region checker and the error responder
`timescale 1ns/100ps
`default_nettype none
interface fab_check_if;
  logic        valid;
  logic [31:0] addr;
  logic [31:0] base;
  logic [4:0]  size_code;
  logic        region_on;
  logic        hit;
  logic        err_start;
  logic        err_busy;
  logic        err_hresp;
  logic        err_hready;
  modport check (input valid, addr, base, size_code, region_on, output hit);
  modport resp  (input err_start, output err_busy, err_hresp, err_hready);
  modport ctl   (output valid, addr, base, size_code, region_on, err_start,
                 input hit, err_busy, err_hresp, err_hready);
endinterface : fab_check_if
`default_nettype wire

//--- design/region_check.sv
// Protected region hit detector for the fabric master
`timescale 1ns/100ps
`default_nettype none
module region_check
(
  fab_check_if.check chk
);
  import bus_matrix_pkg::*;
  logic [5:0]  n_w;
  logic        code_ok;
  logic [31:0] keep;
  logic [31:0] diff;
  assign n_w     = {1'b0, chk.size_code} + SIZE_TO_N;
  // Reserved codes protect nothing rather than an undefined span
  assign code_ok = SIZE_VALID[chk.size_code];
  genvar i;
  for (i = 0; i < 32; i = i + 1)
  begin : g_keep
    assign keep[i] = (6'(i) >= n_w);
  end
  assign diff    = (chk.addr ^ chk.base) & keep;
  assign chk.hit = chk.valid && chk.region_on && code_ok && (diff == 32'h0000_0000);
endmodule : region_check
`default_nettype wire

//--- design/error_resp.sv
// Two-cycle bus error response toward the fabric master
`timescale 1ns/100ps
`default_nettype none
module error_resp
(
  input  wire logic core_clk,
  input  wire logic resetn,
  fab_check_if.resp rsp
);
  import bus_matrix_pkg::*;
  err_state_t state_q;
  err_state_t state_d;
  logic       hresp_q;
  logic       hready_q;
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      RESP_IDLE: if (rsp.err_start) state_d = RESP_WAIT;
      RESP_WAIT: state_d = RESP_DONE;
      RESP_DONE: state_d = RESP_IDLE;
      default:   state_d = RESP_IDLE;
    endcase
  end
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q  <= RESP_IDLE;
      hresp_q  <= 1'b0;
      hready_q <= 1'b1;
    end
    else
    begin
      state_q  <= state_d;
      hresp_q  <= (state_d != RESP_IDLE);
      hready_q <= (state_d != RESP_WAIT);
    end
  end
  assign rsp.err_busy   = (state_q != RESP_IDLE);
  assign rsp.err_hresp  = hresp_q;
  assign rsp.err_hready = hready_q;
endmodule : error_resp
`default_nettype wire

//--- design/bus_matrix_access_control.sv
// Bus matrix access control: master gating, fabric region guard, error flags
// Behaviour
// - Region base is base bits 31 down to N, N from the size code.
// - Region guard off: fabric master reaches every address if its gate is on.
// - Region guard on: fabric accesses inside the region get an error response.
// - Blocked region access sets the fabric error flag and raises the interrupt.
// - Size code 0x0F means 64 KB, bits 31 to 16 compared.
// - Size code 0x10 means 128 KB, bits 31 to 17 compared.
// - Config bit 3 picks round robin (0, reset) or weighted (1).
// - A cleared gate bit cuts its master off; a set bit lets it through.
// - Gate bit 0 fabric, bit 1 Ethernet MAC, bit 2 peripheral DMA.
// - Enabled fabric master is still checked against the protected region.
// - Processor core masters are never gated.
// - Five-bit size code resets to 0x1E; undefined codes are reserved.
// - Error flags are sticky until software writes one to clear them.
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module bus_matrix_access_control
(
  input  wire logic                               core_clk,
  input  wire logic                               resetn,
  input  wire logic                               wb_cyc,
  input  wire logic                               wb_stb,
  input  wire logic                               wb_we,
  input  wire logic [bus_matrix_pkg::ADR_W-1:0]   wb_adr,
  input  wire logic [3:0]                         wb_sel,
  input  wire logic [31:0]                        wb_dat_w,
  output logic      [31:0]                        wb_dat_r,
  output logic                                    wb_ack,
  input  wire logic [bus_matrix_pkg::GATE_W-1:0]  master_req,
  input  wire logic [31:0]                        fab_haddr,
  input  wire logic [bus_matrix_pkg::FLAG_W-1:0]  slave_err,
  output logic      [bus_matrix_pkg::GATE_W-1:0]  master_pass,
  output logic                                    fab_hresp,
  output logic                                    fab_hready,
  output logic      [bus_matrix_pkg::GATE_W-1:0]  master_access_gate,
  output logic                                    weighted_arb_select,
  output logic                                    matrix_error_irq
);
  import bus_matrix_pkg::*;

  fab_check_if chk ();

  logic [31:0]       base_q;
  logic [SIZE_W-1:0] size_q;
  logic [CFG_W-1:0]  cfg_q;
  logic [FLAG_W-1:0] flag_q;
  logic [FLAG_W-1:0] flag_d;
  logic [FLAG_W-1:0] mask_q;
  logic [GATE_W-1:0] pass_q;
  logic [GATE_W-1:0] pass_d;
  logic              irq_q;
  logic              ack_q;
  logic [31:0]       rdat_q;

  wire               access   = wb_cyc && wb_stb && !ack_q;
  wire               wr       = access && wb_we;
  wire [7:0]         ofs      = {wb_adr[ADR_W-1:2], 2'b00};
  wire               sel_base = (ofs == OFS_PROT_BASE);
  wire               sel_size = (ofs == OFS_PROT_SIZE);
  wire               sel_cfg  = (ofs == OFS_MATRIX_CFG);
  wire               sel_stat = (ofs == OFS_STATUS);
  wire               sel_clr  = (ofs == OFS_STATUS_CLR);
  wire               sel_mask = (ofs == OFS_IRQ_MASK);
  wire [31:0]        wmask    = {{8{wb_sel[3]}}, {8{wb_sel[2]}},
                                 {8{wb_sel[1]}}, {8{wb_sel[0]}}};
  wire [31:0]        wbits    = wb_dat_w & wmask;
  wire [FLAG_W-1:0]  clr_w    = (wr && (sel_stat || sel_clr)) ?
                                wbits[FLAG_LSB+FLAG_W-1:FLAG_LSB] : '0;
  wire [FLAG_W-1:0]  fmask_w  = wmask[FLAG_LSB+FLAG_W-1:FLAG_LSB];
  wire [31:0]        rd_mux   =
    sel_base ? base_q :
    sel_size ? {27'h0, size_q} :
    sel_cfg  ? {28'h0, cfg_q} :
    sel_stat ? {23'h0, flag_q, 4'h0} :
    sel_mask ? {23'h0, mask_q, 4'h0} : 32'h0000_0000;

  // Fabric request path: gate first, then the region guard
  wire               fab_ok   = master_req[GATE_FAB] && cfg_q[GATE_FAB];
  wire               fab_blk  = fab_ok && chk.hit && !chk.err_busy;
  wire [FLAG_W-1:0]  event_w  = slave_err | (FLAG_W'(fab_blk) << FLAG_FAB);

  assign chk.valid     = fab_ok;
  assign chk.addr      = fab_haddr;
  assign chk.base      = base_q;
  assign chk.size_code = size_q;
  assign chk.region_on = base_q[REGION_ON_BIT];
  assign chk.err_start = fab_blk;

  region_check u_check
  (
    .chk (chk)
  );

  error_resp u_resp
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .rsp      (chk)
  );

  // A hit while the responder is busy is dropped; the master is stalled then
  assign pass_d[GATE_FAB] = fab_ok && !chk.hit;
  assign pass_d[GATE_MAC] = master_req[GATE_MAC] && cfg_q[GATE_MAC];
  assign pass_d[GATE_DMA] = master_req[GATE_DMA] && cfg_q[GATE_DMA];
  // Set wins over clear so no event is lost; core bits have no gate
  assign flag_d = (flag_q & ~clr_w) | event_w;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q  <= access;
      rdat_q <= access ? rd_mux : rdat_q;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      base_q <= BASE_RST;
      size_q <= SIZE_RST;
      cfg_q  <= CFG_RST;
      mask_q <= MASK_RST;
    end
    else
    begin
      if (wr && sel_base)
        base_q <= (base_q & ~wmask) | wbits;
      if (wr && sel_size && wb_sel[0])
        size_q <= wb_dat_w[SIZE_W-1:0];
      if (wr && sel_cfg && wb_sel[0])
        cfg_q <= wb_dat_w[CFG_W-1:0];
      if (wr && sel_mask)
        mask_q <= (mask_q & ~fmask_w) | wbits[FLAG_LSB+FLAG_W-1:FLAG_LSB];
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flag_q <= FLAG_RST;
      pass_q <= '0;
      irq_q  <= 1'b0;
    end
    else
    begin
      flag_q <= flag_d;
      pass_q <= pass_d;
      irq_q  <= |(flag_d & mask_q);
    end
  end

  assign wb_dat_r            = rdat_q;
  assign wb_ack              = ack_q;
  assign master_pass         = pass_q;
  assign fab_hresp           = chk.err_hresp;
  assign fab_hready          = chk.err_hready;
  assign master_access_gate  = cfg_q[GATE_W-1:0];
  assign weighted_arb_select = cfg_q[WEIGHTED_BIT];
  assign matrix_error_irq    = irq_q;

  AST_GATE_CUT: assert property (@(posedge core_clk) disable iff (!resetn)
    master_req[GATE_DMA] && !cfg_q[GATE_DMA] |=> !master_pass[GATE_DMA])
    else $error("Disabled DMA request passed");

  AST_MAC_BIT: assert property (@(posedge core_clk) disable iff (!resetn)
    master_req[GATE_MAC] && cfg_q[GATE_MAC] |=> master_pass[GATE_MAC])
    else $error("Enabled MAC request not passed");

  AST_FAB_OPEN: assert property (@(posedge core_clk) disable iff (!resetn)
    fab_ok && !base_q[REGION_ON_BIT] |=> master_pass[GATE_FAB] && !fab_hresp)
    else $error("Fabric blocked with region guard off");

  AST_FAB_ERR: assert property (@(posedge core_clk) disable iff (!resetn)
    fab_ok && chk.hit && !chk.err_busy
    |=> fab_hresp && !fab_hready && !master_pass[GATE_FAB] ##1 fab_hresp && fab_hready
    ##1 !fab_hresp)
    else $error("Fabric region hit without two-cycle error");

  AST_FLAG_IRQ: assert property (@(posedge core_clk) disable iff (!resetn)
    fab_blk && mask_q[FLAG_FAB] |=> flag_q[FLAG_FAB] && matrix_error_irq)
    else $error("Blocked fabric access did not flag or interrupt");

  AST_STICKY: assert property (@(posedge core_clk) disable iff (!resetn)
    flag_q[FLAG_FAB] && !clr_w[FLAG_FAB] |=> flag_q[FLAG_FAB])
    else $error("Error flag dropped without a clear");

  AST_WEIGHT: assert property (@(posedge core_clk) disable iff (!resetn)
    wr && sel_cfg && wb_sel[0] |=> weighted_arb_select == $past(wb_dat_w[WEIGHTED_BIT]))
    else $error("Arbitration select not updated by write");

  AST_SIZE16: assert property (@(posedge core_clk) disable iff (!resetn)
    fab_ok && base_q[REGION_ON_BIT] && size_q == 5'h0F
    && fab_haddr[31:16] == base_q[31:16] |-> chk.hit)
    else $error("64 KB region miss");

  AST_SIZE17: assert property (@(posedge core_clk) disable iff (!resetn)
    fab_ok && size_q == 5'h10 && fab_haddr[31:17] != base_q[31:17] |-> !chk.hit)
    else $error("128 KB region hit outside span");

  AST_CORE: assert property (@(posedge core_clk) disable iff (!resetn)
    slave_err[FLAG_CORE_SYS] |=> flag_q[FLAG_CORE_SYS])
    else $error("Core error not flagged");

  AST_TOP_BIT: assert property (@(posedge core_clk) disable iff (!resetn)
    chk.hit |-> fab_haddr[31] == base_q[31])
    else $error("Region hit with address top bit outside base");

  AST_BASE_WRITE: assert property (@(posedge core_clk) disable iff (!resetn)
    wr && sel_base && wb_sel == 4'hF |=> base_q == $past(wb_dat_w))
    else $error("Base register not loaded by full write");

  AST_REGION_OFF: assert property (@(posedge core_clk) disable iff (!resetn)
    !base_q[REGION_ON_BIT] |-> !chk.hit)
    else $error("Region hit while guard is off");

  AST_FAB_MISS_PASS: assert property (@(posedge core_clk) disable iff (!resetn)
    fab_ok && !chk.hit |=> master_pass[GATE_FAB])
    else $error("Enabled fabric miss not passed");

  AST_IDLE_RESP: assert property (@(posedge core_clk) disable iff (!resetn)
    !chk.err_busy && !chk.err_start |=> fab_hready && !fab_hresp)
    else $error("Error response without a blocked access");

  AST_SET_FLAG: assert property (@(posedge core_clk) disable iff (!resetn)
    event_w[FLAG_FAB] |=> flag_q[FLAG_FAB])
    else $error("Fabric error event lost");

  AST_IRQ_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    flag_q[FLAG_FAB] && mask_q[FLAG_FAB] && !clr_w[FLAG_FAB] |=> matrix_error_irq)
    else $error("Interrupt low while unmasked flag set");

  AST_IRQ_LOW: assert property (@(posedge core_clk) disable iff (!resetn)
    flag_q == '0 && slave_err == '0 && !fab_blk |=> !matrix_error_irq)
    else $error("Interrupt high with no flag set");

  AST_SIZE16_OUT: assert property (@(posedge core_clk) disable iff (!resetn)
    fab_ok && size_q == 5'h0F
    && fab_haddr[31:16] != base_q[31:16] |-> !chk.hit)
    else $error("64 KB region hit outside span");

  AST_SIZE17_IN: assert property (@(posedge core_clk) disable iff (!resetn)
    fab_ok && base_q[REGION_ON_BIT] && size_q == 5'h10
    && fab_haddr[31:17] == base_q[31:17] |-> chk.hit)
    else $error("128 KB region miss");

  AST_GATE_LOAD: assert property (@(posedge core_clk) disable iff (!resetn)
    wr && sel_cfg && wb_sel[0] |=> master_access_gate == $past(wb_dat_w[GATE_W-1:0]))
    else $error("Master gate not updated by write");

  AST_MAC_CUT: assert property (@(posedge core_clk) disable iff (!resetn)
    master_req[GATE_MAC] && !cfg_q[GATE_MAC] |=> !master_pass[GATE_MAC])
    else $error("Disabled MAC request passed");

  AST_FAB_GATED: assert property (@(posedge core_clk) disable iff (!resetn)
    master_req[GATE_FAB] && !cfg_q[GATE_FAB] && !chk.err_busy
    |=> !master_pass[GATE_FAB] && !fab_hresp)
    else $error("Disabled fabric request passed or errored");

  AST_DMA_BIT: assert property (@(posedge core_clk) disable iff (!resetn)
    master_req[GATE_DMA] && cfg_q[GATE_DMA] |=> master_pass[GATE_DMA])
    else $error("Enabled DMA request not passed");

  AST_HIT_NO_PASS: assert property (@(posedge core_clk) disable iff (!resetn)
    chk.hit |=> !master_pass[GATE_FAB])
    else $error("Fabric region hit passed to the matrix");

  AST_CORE_ID: assert property (@(posedge core_clk) disable iff (!resetn)
    slave_err[FLAG_CORE_ID] |=> flag_q[FLAG_CORE_ID])
    else $error("Core code bus error not flagged");

  AST_SIZE_LOAD: assert property (@(posedge core_clk) disable iff (!resetn)
    wr && sel_size && wb_sel[0] |=> size_q == $past(wb_dat_w[SIZE_W-1:0]))
    else $error("Size code not updated by write");

  AST_SIZE_2G: assert property (@(posedge core_clk) disable iff (!resetn)
    fab_ok && base_q[REGION_ON_BIT] && size_q == 5'h1E
    && fab_haddr[31] == base_q[31] |-> chk.hit)
    else $error("2 GB region miss");

  AST_RESERVED: assert property (@(posedge core_clk) disable iff (!resetn)
    size_q == 5'h13 |-> !chk.hit)
    else $error("Reserved size code protected a region");

  AST_CLEAR: assert property (@(posedge core_clk) disable iff (!resetn)
    clr_w[FLAG_FAB] && !event_w[FLAG_FAB] |=> !flag_q[FLAG_FAB])
    else $error("Fabric flag not cleared by write");

  AST_STICKY_CORE: assert property (@(posedge core_clk) disable iff (!resetn)
    flag_q[FLAG_CORE_SYS] && !clr_w[FLAG_CORE_SYS] |=> flag_q[FLAG_CORE_SYS])
    else $error("Core flag dropped without a clear");

endmodule : bus_matrix_access_control
`default_nettype wire

//--- bench/master_model.sv
// Far-side master model: one request per command, address bus inverted every cycle after it
`timescale 1ns/100ps
`default_nettype none
module master_model
(
  input  wire logic                              core_clk,
  input  wire logic                              go,
  input  wire logic [bus_matrix_pkg::GATE_W-1:0] go_req,
  input  wire logic [31:0]                       go_addr,
  output logic      [bus_matrix_pkg::GATE_W-1:0] master_req,
  output logic      [31:0]                       fab_haddr
);
  import bus_matrix_pkg::*;
  // Idle bus inverts the address every cycle, so it alternates between the inverse and the last address
  always_ff @(posedge core_clk)
  begin
    master_req <= go ? go_req : '0;
    fab_haddr  <= go ? go_addr : ~fab_haddr;
  end
endmodule : master_model
`default_nettype wire

//--- bench/test_bus_matrix_access_control.sv
// Self-checking bench for the bus matrix access control
`timescale 1ns/100ps
`default_nettype none
module test_bus_matrix_access_control;
  import bus_matrix_pkg::*;
  logic              core_clk, resetn, wb_cyc, wb_stb, wb_we, wb_ack, go;
  logic              fab_hresp, fab_hready, weighted, irq;
  logic [ADR_W-1:0]  wb_adr;
  logic [3:0]        wb_sel;
  logic [31:0]       wb_dat_w, wb_dat_r, fab_haddr, go_addr, rd;
  logic [GATE_W-1:0] master_req, master_pass, gate, go_req;
  logic [FLAG_W-1:0] slave_err;
  int                n_mismatch, num_checks;

  bus_matrix_access_control dut (.core_clk(core_clk), .resetn(resetn), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .master_req(master_req), .fab_haddr(fab_haddr),
    .slave_err(slave_err), .master_pass(master_pass), .fab_hresp(fab_hresp),
    .fab_hready(fab_hready), .master_access_gate(gate), .weighted_arb_select(weighted),
    .matrix_error_irq(irq));
  master_model far (.core_clk(core_clk), .go(go), .go_req(go_req), .go_addr(go_addr),
    .master_req(master_req), .fab_haddr(fab_haddr));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= adr;
    wb_dat_w <= d;
    do
      @(posedge core_clk);
    while (wb_ack !== 1'b1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  task automatic rdchk(input logic [ADR_W-1:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk($sformatf("reg %h", adr), rd, exp);
  endtask : rdchk

  // Request, then the pass and the two-cycle error answer, then the idle response
  task automatic probe(input logic [2:0] r, input logic [31:0] a, input logic [2:0] ep,
                       input logic err);
    @(posedge core_clk);
    go      <= 1'b1;
    go_req  <= r;
    go_addr <= a;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("pass", master_pass, ep);
    chk("resp first", {fab_hresp, fab_hready}, {err, !err});
    if (err)
    begin
      @(posedge core_clk);
      #1;
      chk("resp second", {fab_hresp, fab_hready}, 2'b11);
    end
    @(posedge core_clk);
    #1;
    chk("resp idle", fab_hresp, 1'b0);
  endtask : probe

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Under two hundred cycles are needed; this is generous
  initial
  begin
    #40000;
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    {resetn, wb_cyc, wb_stb, wb_we, go} = '0;
    {wb_adr, wb_dat_w, go_req, go_addr, slave_err} = '0;
    wb_sel = 4'hF;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    rdchk(8'h00, 32'h0000_0000);
    rdchk(8'h04, 32'h0000_001E);
    rdchk(8'h08, 32'h0000_0000);
    chk("gate weighted irq", {gate, weighted, irq}, 5'h00);
    wb(1'b1, 8'h18, 32'hFFFF_FFFF);
    rdchk(8'h18, 32'h0000_0000);
    probe(3'h7, 32'h6000_0000, 3'h0, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      wb(1'b1, 8'h08, 32'h1 << i);
      chk("gate", gate, 3'h1 << i);
      probe(3'h7, 32'h6000_0000, 3'h1 << i, 1'b0);
    end
    wb(1'b1, 8'h08, 32'h0000_000F);
    chk("weighted gate", {weighted, gate}, 4'hF);
    wb(1'b1, 8'h04, 32'h0000_000F);
    wb(1'b1, 8'h00, 32'h6001_0000);
    probe(3'h1, 32'h6001_0000, 3'h1, 1'b0);
    wb(1'b1, 8'h00, 32'h6001_0001);
    probe(3'h1, 32'h6001_FFFC, 3'h0, 1'b1);
    chk("irq", irq, 1'b1);
    rdchk(8'h0C, 32'h0000_0040);
    probe(3'h1, 32'h6002_0000, 3'h1, 1'b0);
    probe(3'h1, 32'h6000_FFFC, 3'h1, 1'b0);
    wb(1'b1, 8'h04, 32'h0000_0010);
    wb(1'b1, 8'h00, 32'h6002_0001);
    probe(3'h1, 32'h6002_0000, 3'h0, 1'b1);
    probe(3'h1, 32'h6003_FFFC, 3'h0, 1'b1);
    probe(3'h1, 32'h6004_0000, 3'h1, 1'b0);
    probe(3'h1, 32'h6001_FFFC, 3'h1, 1'b0);
    wb(1'b1, 8'h04, 32'h0000_0013);
    probe(3'h1, 32'h6002_0000, 3'h1, 1'b0);
    wb(1'b1, 8'h04, 32'h0000_001E);
    probe(3'h1, 32'h0000_1000, 3'h0, 1'b1);
    probe(3'h1, 32'h8000_0000, 3'h1, 1'b0);
    wb(1'b1, 8'h04, 32'h0000_0010);
    rdchk(8'h0C, 32'h0000_0040);
    wb(1'b1, 8'h10, 32'h0000_0040);
    rdchk(8'h0C, 32'h0000_0000);
    chk("irq cleared", irq, 1'b0);
    wb(1'b1, 8'h14, 32'h0000_0000);
    probe(3'h1, 32'h6002_0000, 3'h0, 1'b1);
    chk("irq masked", irq, 1'b0);
    wb(1'b1, 8'h14, 32'h0000_0040);
    @(posedge core_clk);
    #1;
    chk("irq unmasked", irq, 1'b1);
    wb(1'b1, 8'h0C, 32'h0000_0040);
    wb(1'b1, 8'h08, 32'h0000_0006);
    probe(3'h1, 32'h6002_0000, 3'h0, 1'b0);
    wb(1'b1, 8'h08, 32'h0000_0000);
    @(posedge core_clk);
    slave_err <= 5'h03;
    @(posedge core_clk);
    slave_err <= 5'h00;
    rdchk(8'h0C, 32'h0000_0030);
    wrap_up();
  end
endmodule : test_bus_matrix_access_control
`default_nettype wire
